// ==== hdl/rtc_core.sv ====
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
// Overview of operation
// - ten 16-bit backup words, twenty bytes, kept across system reset
// - count clock picked from low ext, low rc, or fast osc over 128
// - counters keep running once started, no software restart needed
// - 32-bit loadable counter compared with alarm word; match raises alarm
// - 20-bit prescaler; reset reload makes one tick per second at 32768 Hz
// - two interrupt sources: alarm match and periodic tick
// - a 512 Hz calibration clock from the time base is driven out
module rtc_core
    import rtc_pkg::*;
(
    input  wire logic        i_clock,       // system clock, 50 MHz
    input  wire logic        i_rst,         // sync reset, active high
    input  wire logic        i_low_ext_clk, // 32.768 kHz external clock
    input  wire logic        i_low_rc_clk,  // internal low-power rc
    input  wire logic        i_fast_external_osc, // fast ext oscillator
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb enable
    input  wire logic        pwrite,        // apb direction
    input  wire logic [7:0]  paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error
    output logic             o_alarm_irq,   // alarm interrupt level
    output logic             o_tick_irq,    // periodic interrupt level
    output logic             o_cal_out      // 512 Hz calibration clock
);

    // ------------------------------------------------------------
    // pin synchronisers, three stages
    // ------------------------------------------------------------
    logic [2:0] sync_ext_r;
    logic [2:0] sync_rc_r;
    logic [2:0] sync_fast_r;
    logic       lvl_ext_r;
    logic       lvl_rc_r;
    logic       lvl_fast_r;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sync_ext_r  <= 3'h0;
            sync_rc_r   <= 3'h0;
            sync_fast_r <= 3'h0;
        end else begin
            sync_ext_r  <= {sync_ext_r[1:0], i_low_ext_clk};
            sync_rc_r   <= {sync_rc_r[1:0], i_low_rc_clk};
            sync_fast_r <= {sync_fast_r[1:0], i_fast_external_osc};
        end
    end

    // level follows once stages two and three agree
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            lvl_ext_r  <= 1'b0;
            lvl_rc_r   <= 1'b0;
            lvl_fast_r <= 1'b0;
        end else begin
            if (sync_ext_r[1] == sync_ext_r[2])
                lvl_ext_r <= sync_ext_r[2];
            if (sync_rc_r[1] == sync_rc_r[2])
                lvl_rc_r <= sync_rc_r[2];
            if (sync_fast_r[1] == sync_fast_r[2])
                lvl_fast_r <= sync_fast_r[2];
        end
    end

    function automatic logic rise(input logic now_v, input logic old_v);
        return now_v & ~old_v;
    endfunction

    logic old_ext_r;
    logic old_rc_r;
    logic old_fast_r;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            old_ext_r  <= 1'b0;
            old_rc_r   <= 1'b0;
            old_fast_r <= 1'b0;
        end else begin
            old_ext_r  <= lvl_ext_r;
            old_rc_r   <= lvl_rc_r;
            old_fast_r <= lvl_fast_r;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [5:0]       ctrl_r;
    logic [1:0]       flag_r;
    logic [PRE_W-1:0] preload_r;
    logic [PRE_W-1:0] div_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] alarm_r;
    logic [BKP_W-1:0] bkp_r [BKP_N];
    logic [6:0]       fast_cnt_r;
    logic [5:0]       cal_cnt_r;
    logic             cal_r;

    src_sel_t src;
    assign src = src_sel_t'(ctrl_r[CTRL_SRC_LO +: 2]);

    // ------------------------------------------------------------
    // clock source pick
    // ------------------------------------------------------------
    logic fast_edge;
    logic src_edge;
    assign fast_edge = rise(lvl_fast_r, old_fast_r);

    // free-running divide by 128 of the fast pin
    always_ff @(posedge i_clock) begin
        if (i_rst)
            fast_cnt_r <= 7'h00;
        else if (fast_edge)
            fast_cnt_r <= fast_cnt_r + 7'h01;
    end

    always_comb begin
        case (src)
            SRC_LOW_EXT:  src_edge = rise(lvl_ext_r, old_ext_r);
            SRC_LOW_RC:   src_edge = rise(lvl_rc_r, old_rc_r);
            SRC_FAST_DIV: src_edge = fast_edge
                                     && fast_cnt_r == FAST_DIV;
            default:      src_edge = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic       wr;
    logic       rd_hit;
    logic       is_bkp;
    logic [3:0] bkp_idx;

    assign pready  = 1'b1;
    assign is_bkp  = paddr >= ADDR_BKP_BASE && paddr <= ADDR_BKP_LAST
                     && paddr[1:0] == 2'h0;
    assign bkp_idx = 4'((paddr - ADDR_BKP_BASE) >> 2);
    assign rd_hit  = is_bkp || paddr == ADDR_CTRL || paddr == ADDR_STATUS
                     || paddr == ADDR_PRELOAD || paddr == ADDR_COUNT
                     || paddr == ADDR_ALARM || paddr == ADDR_DIVREAD;
    assign pslverr = psel && penable && !rd_hit;
    assign wr      = psel && penable && pwrite && rd_hit;

    function automatic logic wr_at(input logic [7:0] a);
        return wr && paddr == a;
    endfunction

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    logic tick;
    logic run;
    assign run  = ctrl_r[CTRL_RUN];
    assign tick = run && src_edge && div_r == '0;

    always_ff @(posedge i_clock) begin
        if (i_rst)
            ctrl_r <= 6'h00;
        else if (wr_at(ADDR_CTRL))
            ctrl_r <= pwdata[5:0];
    end

    always_ff @(posedge i_clock) begin
        if (i_rst)
            preload_r <= PRELOAD_RST;
        else if (wr_at(ADDR_PRELOAD))
            preload_r <= pwdata[PRE_W-1:0];
    end

    // divider reloads itself, never waits for software
    always_ff @(posedge i_clock) begin
        if (i_rst)
            div_r <= PRELOAD_RST;
        else if (wr_at(ADDR_PRELOAD))
            div_r <= pwdata[PRE_W-1:0];
        else if (run && src_edge) begin
            if (div_r == '0)
                div_r <= preload_r;
            else
                div_r <= div_r - 20'h00001;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst)
            count_r <= '0;
        else if (wr_at(ADDR_COUNT))
            count_r <= pwdata;
        else if (tick)
            count_r <= count_r + 32'h00000001;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst)
            alarm_r <= '1;
        else if (wr_at(ADDR_ALARM))
            alarm_r <= pwdata;
    end

    // ------------------------------------------------------------
    // flags: write one to clear, a new event wins
    // ------------------------------------------------------------
    logic alarm_hit;
    // match against the value the count takes at this tick
    assign alarm_hit = tick && (count_r + 32'h00000001) == alarm_r;

    always_ff @(posedge i_clock) begin
        if (i_rst)
            flag_r <= 2'h0;
        else begin
            if (alarm_hit)
                flag_r[STAT_ALARM] <= 1'b1;
            else if (wr_at(ADDR_STATUS) && pwdata[STAT_ALARM])
                flag_r[STAT_ALARM] <= 1'b0;
            if (tick)
                flag_r[STAT_TICK] <= 1'b1;
            else if (wr_at(ADDR_STATUS) && pwdata[STAT_TICK])
                flag_r[STAT_TICK] <= 1'b0;
        end
    end

    // outputs follow the flags one cycle later
    always_ff @(posedge i_clock) begin
        if (i_rst)
            o_alarm_irq <= 1'b0;
        else
            o_alarm_irq <= flag_r[STAT_ALARM]
                           && ctrl_r[CTRL_ALRM_IE];
    end

    always_ff @(posedge i_clock) begin
        if (i_rst)
            o_tick_irq <= 1'b0;
        else
            o_tick_irq <= flag_r[STAT_TICK]
                          && ctrl_r[CTRL_TICK_IE];
    end

    // ------------------------------------------------------------
    // 512 Hz: toggle every 32 source edges (32768/64)
    // ------------------------------------------------------------
    // held at a clean phase while off, so enabling never
    // shortens the first half period on the pin
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cal_cnt_r <= 6'h00;
            cal_r     <= 1'b0;
        end else if (!ctrl_r[CTRL_CAL_EN]) begin
            cal_cnt_r <= 6'h00;
            cal_r     <= 1'b0;
        end else if (run && src_edge) begin
            cal_cnt_r <= cal_cnt_r + 6'h01;
            if (cal_cnt_r[4:0] == CAL_DIV[4:0])
                cal_r <= ~cal_r;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst)
            o_cal_out <= 1'b0;
        else
            o_cal_out <= cal_r && ctrl_r[CTRL_CAL_EN];
    end

    // ------------------------------------------------------------
    // backup store, no reset: survives a system reset
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (wr && is_bkp)
            bkp_r[bkp_idx] <= pwdata[BKP_W-1:0];
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h00000000;
        if (is_bkp)
            rd_mux = {16'h0000, bkp_r[bkp_idx]};
        else begin
            case (paddr)
                ADDR_CTRL:    rd_mux = {26'h0, ctrl_r};
                ADDR_STATUS:  rd_mux = {30'h0, flag_r};
                ADDR_PRELOAD: rd_mux = {12'h0, preload_r};
                ADDR_COUNT:   rd_mux = count_r;
                ADDR_ALARM:   rd_mux = alarm_r;
                ADDR_DIVREAD: rd_mux = {12'h0, div_r};
                default:      rd_mux = 32'h00000000;
            endcase
        end
    end

    // taken at the end of setup, stands through the access phase
    always_ff @(posedge i_clock) begin
        if (i_rst)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
            prdata <= rd_mux;
    end

endmodule

// ==== hdl/rtc_pkg.sv ====
package rtc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_PRELOAD  = 8'h08;
    localparam logic [7:0] ADDR_COUNT    = 8'h0C;
    localparam logic [7:0] ADDR_ALARM    = 8'h10;
    localparam logic [7:0] ADDR_DIVREAD  = 8'h14;
    localparam logic [7:0] ADDR_BKP_BASE = 8'h20;
    localparam logic [7:0] ADDR_BKP_LAST = 8'h44;

    // ------------------------------------------------------------
    // control and status fields
    // ------------------------------------------------------------
    localparam int CTRL_RUN      = 0;
    localparam int CTRL_SRC_LO   = 1;
    localparam int CTRL_CAL_EN   = 3;
    localparam int CTRL_ALRM_IE  = 4;
    localparam int CTRL_TICK_IE  = 5;
    localparam int STAT_ALARM    = 0;
    localparam int STAT_TICK     = 1;

    // ------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------
    localparam int PRE_W         = 20;
    localparam int CNT_W         = 32;
    localparam int BKP_W         = 16;
    localparam int BKP_N         = 10;
    localparam logic [19:0] PRELOAD_RST = 20'h07FFF;
    localparam logic [6:0]  FAST_DIV    = 7'h7F;
    localparam logic [5:0]  CAL_DIV     = 6'h3F;

    // clock source selection
    typedef enum logic [1:0] {
        SRC_LOW_EXT  = 2'h0,
        SRC_LOW_RC   = 2'h1,
        SRC_FAST_DIV = 2'h2
    } src_sel_t;

endpackage

// ==== bench/rtc_core_properties.sv ====
`timescale 1ns/1ps
module rtc_core_chk
    import rtc_pkg::*;
(
    input wire logic        i_clock,     // clock
    input wire logic        i_rst,       // reset
    input wire logic        psel,        // apb
    input wire logic        penable,     // apb
    input wire logic        pwrite,      // apb
    input wire logic [7:0]  paddr,       // apb
    input wire logic [31:0] pwdata,      // apb
    input wire logic [31:0] prdata,      // apb
    input wire logic        pready,      // apb
    input wire logic        pslverr,     // apb
    input wire logic        o_alarm_irq, // alarm
    input wire logic        o_tick_irq,  // tick
    input wire logic        o_cal_out    // cal
);
    logic [5:0] ctrl_sh;
    logic       acc, mapped, bkp, clr_a, clr_t;
    assign acc = psel && penable;
    assign bkp = paddr >= ADDR_BKP_BASE && paddr <= ADDR_BKP_LAST;
    assign mapped = paddr[1:0] == 2'h0 && (paddr <= ADDR_DIVREAD || bkp);
    assign clr_a = acc && pwrite && paddr == ADDR_STATUS && pwdata[0];
    assign clr_t = acc && pwrite && paddr == ADDR_STATUS && pwdata[1];
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ctrl_sh <= 6'h00;
        end else if (acc && pwrite && paddr == ADDR_CTRL) begin
            ctrl_sh <= pwdata[5:0];
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_err_unmapped: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr wrong");
    chk_rd_unmapped: assert property (
        acc && !pwrite && !mapped |-> prdata == 0)
        else $error("unmapped read not zero");
    chk_bkp_upper: assert property (
        acc && !pwrite && bkp |-> prdata[31:16] == 16'h0)
        else $error("backup upper bits set");
    chk_alarm_mask: assert property (!ctrl_sh[4] |=> !o_alarm_irq)
        else $error("alarm irq while masked");
    chk_tick_mask: assert property (!ctrl_sh[5] |=> !o_tick_irq)
        else $error("tick irq while masked");
    chk_tick_hold: assert property (
        o_tick_irq && ctrl_sh[5] && !clr_t && !$past(clr_t) |=> o_tick_irq)
        else $error("tick irq dropped");
    chk_alarm_hold: assert property (
        o_alarm_irq && ctrl_sh[4] && !clr_a && !$past(clr_a) |=> o_alarm_irq)
        else $error("alarm irq dropped");
    chk_cal_rate: assert property (
        $changed(o_cal_out) |=> $stable(o_cal_out) [*8])
        else $error("cal out too fast");
endmodule
bind rtc_core rtc_core_chk u_chk (.i_clock, .i_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .o_alarm_irq,
    .o_tick_irq, .o_cal_out);

// ==== bench/test_rtc_core.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_rtc_core
    import rtc_pkg::*;
;
    logic        i_clock, i_rst, psel, penable, pwrite, erv, cal_q;
    logic        i_low_ext_clk, i_low_rc_clk, i_fast_external_osc;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv, c, v;
    logic        pready, pslverr, o_alarm_irq, o_tick_irq, o_cal_out;
    logic [31:0] bk [BKP_N];
    int          n_errors = 0, checked = 0, cyc = 0, ph = 0, tog;
    int          per [3] = '{64, 80, 1024};
    rtc_core u_rtc_core (.i_clock, .i_rst, .i_low_ext_clk, .i_low_rc_clk,
        .i_fast_external_osc, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .o_alarm_irq, .o_tick_irq, .o_cal_out);
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    // source pins and run limit
    always @(posedge i_clock) begin
        ph <= ph + 1;
        cyc <= cyc + 1;
        i_low_ext_clk <= (ph % 16) < 8;
        i_low_rc_clk <= (ph % 20) < 10;
        i_fast_external_osc <= ph[2];
        if (cyc == 40000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
        @(posedge i_clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        do @(posedge i_clock); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitc(input int n);
        tog = 0;
        repeat (n) begin
            @(posedge i_clock);
            if (o_cal_out !== cal_q) tog++;
            cal_q = o_cal_out;
        end
    endtask
    function automatic logic near(input int g, input int e);
        return g >= e - 1 && g <= e + 1;
    endfunction
    initial begin
        {psel, penable, pwrite, paddr, pwdata, cal_q} = '0;
        i_rst = 1'b1;
        void'($urandom(41710));
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        apb(0, ADDR_PRELOAD, 0);
        `CHK(rdv, 32'(PRELOAD_RST))
        apb(0, ADDR_DIVREAD, 0);
        `CHK(rdv, 32'(PRELOAD_RST))
        apb(0, ADDR_ALARM, 0);
        `CHK(rdv, 32'hFFFFFFFF)
        for (int i = 0; i < BKP_N; i++) begin
            bk[i] = $urandom;
            apb(1, ADDR_BKP_BASE + 8'(4 * i), bk[i]);
        end
        for (int i = 0; i < BKP_N; i++) begin
            apb(0, ADDR_BKP_BASE + 8'(4 * i), 0);
            `CHK(rdv, {16'h0, bk[i][15:0]})
        end
        apb(1, 8'h48, 32'hFFFFFFFF);
        apb(0, 8'h48, 0);
        `CHK({erv, rdv}, {1'b1, 32'h0})
        for (int s = 0; s < 3; s++) begin
            c = 32'h0;
            c[CTRL_RUN] = 1'b1;
            c[CTRL_SRC_LO +: 2] = 2'(s);
            c[CTRL_TICK_IE] = 1'b1;
            apb(1, ADDR_CTRL, 0);
            apb(1, ADDR_PRELOAD, s == 2 ? 32'h0 : 32'h3);
            apb(1, ADDR_COUNT, 0);
            apb(1, ADDR_STATUS, 32'h3);
            apb(1, ADDR_CTRL, c);
            waitc(per[s] * 10);
            apb(1, ADDR_CTRL, 32'h20);
            apb(0, ADDR_COUNT, 0);
            `CHK(near(int'(rdv), 10), 1'b1)
            `CHK(o_tick_irq, 1'b1)
            apb(1, ADDR_STATUS, 32'h2);
            apb(0, ADDR_STATUS, 0);
            `CHK(rdv[STAT_TICK], 1'b0)
        end
        for (int k = 0; k < 2; k++) begin
            v = k ? 32'hFFFFFFFF : $urandom;
            apb(1, ADDR_CTRL, 0);
            apb(1, ADDR_STATUS, 32'h3);
            apb(1, ADDR_PRELOAD, 32'h3);
            apb(1, ADDR_COUNT, v);
            apb(1, ADDR_ALARM, v + 32'h2);
            apb(1, ADDR_CTRL, 32'h11);
            waitc(100);
            `CHK(o_alarm_irq, 1'b0)
            waitc(200);
            `CHK(o_alarm_irq, 1'b1)
        end
        apb(1, ADDR_CTRL, 32'h09);
        waitc(5120);
        `CHK(near(tog, 10), 1'b1)
        stop_test();
    end
endmodule
